// ---- core/fbd_pkg.sv ----
package fbd_pkg;
  // Bus map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG_A = 8'h04;
  localparam logic [7:0] REG_CFG_B = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_FREQ = 8'h10;
  localparam logic [7:0] REG_CMDWORD = 8'h14;
  localparam logic [7:0] REG_EPR = 8'h18;
  // Field positions
  localparam int CTRL_PANEL_BIT = 0;
  localparam int CFG_POLICY_BIT = 0;
  localparam int CFG_BAUD_BIT = 1;
  localparam int CW_FWD_BIT = 1;
  localparam int CW_REV_BIT = 2;
  // Reset values, constants and limits
  localparam logic [1:0] BAUD_125K = 2'h0;
  localparam logic [1:0] POLICY_DEF = 2'h0;
  localparam logic [1:0] POLICY_IGNORE = 2'h2;
  localparam logic [7:0] ASM_CLASS = 8'h04;
  localparam logic [7:0] ASM_OUT_DEF = 8'h15;
  localparam logic [7:0] ASM_IN_DEF = 8'h47;
  localparam logic [7:0] NODE_CLASS = 8'h03;
  localparam logic [5:0] NODE_MAX = 6'h3F;
  localparam logic [15:0] FREQ_MAX = 16'h9C40;
  localparam logic [15:0] EPR_DEF_MS = 16'h0000;
  localparam int EPR_MULT = 4;
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam longint READY_TIME_MS = 60000;
  localparam longint MS_NS = 1000000;
  localparam int MS_CYCLES = int'(MS_NS / CLK_PERIOD_NS);
  localparam longint READY_CYCLES = READY_TIME_MS * MS_CYCLES;
  // Link request codes
  typedef enum logic [3:0] {
    OP_CONNECT = 4'h0,
    OP_CTRL_WORD = 4'h1,
    OP_FREQ = 4'h2,
    OP_MONITOR = 4'h3,
    OP_PARAM_RD = 4'h4,
    OP_RESET_SVC = 4'h5,
    OP_SET_ADDR = 4'h6,
    OP_SET_BAUD = 4'h7,
    OP_SET_EPR = 4'h8
  } fbd_op_t;
  // Link states
  typedef enum logic [3:0] {
    ST_BOOT = 4'h1,
    ST_IDLE = 4'h2,
    ST_CONN = 4'h4,
    ST_LOST = 4'h8
  } fbd_state_t;
endpackage : fbd_pkg

// ---- core/fbd_loss_timer.sv ----
`timescale 1ns/1ps
module fbd_loss_timer #(
  parameter int MS_CYC = fbd_pkg::MS_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  input wire logic arm_i,
  input wire logic kick_i,
  input wire logic [15:0] epr_ms_i,
  output logic expired_o
);
  import fbd_pkg::*;

  logic [31:0] pre;
  logic [17:0] ms_cnt;
  logic done;
  wire tick = (pre == 32'(MS_CYC - 1));
  wire [17:0] limit = 18'(epr_ms_i) * 18'(EPR_MULT);
  wire hit = arm_i && !done && tick && (limit != 18'h00000)
             && (ms_cnt + 18'h00001 == limit);

  // Millisecond prescaler and silent-period counter
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pre <= 32'h00000000;
      ms_cnt <= 18'h00000;
      done <= 1'b0;
    end else if (ce_i) begin
      if (kick_i || !arm_i) begin
        pre <= 32'h00000000;
        ms_cnt <= 18'h00000;
        done <= 1'b0;
      end else if (!done) begin
        pre <= tick ? 32'h00000000 : pre + 32'h00000001;
        if (tick)
          ms_cnt <= ms_cnt + 18'h00001;
        if (hit)
          done <= 1'b1;
      end
    end
  end

  assign expired_o = hit && ce_i;

  a_expiry_once: assert property (@(posedge clk_i) disable iff (!resetn_i)
    expired_o |=> !expired_o)
    else $error("loss timeout fired twice");
endmodule : fbd_loss_timer

// ---- core/fbd_cmd_port.sv ----
`timescale 1ns/1ps
// What this block does
// - Answers only requests, never originates traffic
// - Ready for link within one minute
// - Second master may read, not control
// - Bit rate starts at 125 kbit/s
// - Bit rate set by network or config
// - Switch address default, network may overwrite
// - Default assemblies class 4, 21, 71
// - Loss policy in two config registers, 0
// - Policy 0: four silent periods, fault, coast
// - Policy 2: keep running, auto reconnect
// - Mode change only stopped, runs off
// - Net mode takes run/frequency; reads in either mode, only when connected
// - Network reset refused during link fault
// - Frequency 0 to 400 Hz, 0.01 Hz
// - Reset service clears params per variant
// - Status byte bit layout
// - Terminals: no run, reset honoured
// - Switches sampled once, above 63 -> 63
// - Control word bit 1 fwd, 2 rev
module fbd_cmd_port #(
  parameter longint READY_CYC = fbd_pkg::READY_CYCLES,
  parameter int MS_CYC = fbd_pkg::MS_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic ce_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Link requests from the fieldbus layer
  input wire logic req_valid_i,
  input wire fbd_pkg::fbd_op_t req_op_i,
  input wire logic req_master_i,
  input wire logic [15:0] req_data_i,
  output logic rsp_valid_o,
  output logic rsp_ok_o,
  output logic [15:0] rsp_data_o,
  // Drive side
  input wire logic [3:0] node_sw_tens_i,
  input wire logic [3:0] node_sw_units_i,
  input wire logic running_i,
  input wire logic forward_running_flag_i,
  input wire logic reverse_running_flag_i,
  input wire logic at_speed_flag_i,
  input wire logic overload_flag_i,
  input wire logic freq_detect_flag_i,
  input wire logic alarm_i,
  input wire logic [15:0] out_freq_i,
  input wire logic term_reset_i,
  input wire logic term_run_i,
  output logic run_forward_cmd_o,
  output logic run_reverse_cmd_o,
  output logic [15:0] freq_setpoint_o,
  output logic option_link_fault_o,
  output logic coast_stop_o,
  output logic drive_reset_o,
  output logic [1:0] param_clear_o,
  output logic panel_unit_o,
  output logic link_ready_o,
  output logic [5:0] node_addr_o,
  output logic [1:0] baud_sel_o,
  output logic [7:0] asm_out_inst_o,
  output logic [7:0] asm_in_inst_o
);
  import fbd_pkg::*;

  fbd_state_t state;
  fbd_state_t next_state;
  logic [63:0] boot_cnt;
  logic [7:0] cfg_a;
  logic [7:0] cfg_b;
  logic [15:0] epr_ms;
  logic addr_taken;
  logic expired;

  // Decoded link request
  wire take = req_valid_i && ce_i;
  wire policy_ign = ({cfg_b[CFG_POLICY_BIT], cfg_a[CFG_POLICY_BIT]}
                     == POLICY_IGNORE);
  wire auto_back = (state == ST_LOST) && policy_ign;
  wire conn = (state == ST_CONN) || auto_back;
  wire ctl_master = !req_master_i;
  wire stopped = !running_i && !run_forward_cmd_o && !run_reverse_cmd_o;
  wire net_ctl = conn && ctl_master && !panel_unit_o
                 && !option_link_fault_o;
  wire freq_in = req_data_i <= FREQ_MAX;
  wire addr_in = req_data_i <= 16'(NODE_MAX);
  wire rd_ok = conn;
  wire cfg_ok = conn && ctl_master;
  logic ok;
  always_comb begin
    unique case (req_op_i)
      OP_CONNECT: ok = (state != ST_BOOT);
      OP_CTRL_WORD: ok = net_ctl;
      OP_FREQ: ok = net_ctl && freq_in;
      OP_MONITOR: ok = rd_ok;
      OP_PARAM_RD: ok = rd_ok;
      OP_RESET_SVC: ok = net_ctl;
      OP_SET_ADDR: ok = cfg_ok && addr_in;
      OP_SET_BAUD: ok = cfg_ok;
      OP_SET_EPR: ok = cfg_ok;
      default: ok = 1'b0;
    endcase
  end
  wire acc = take && ok;
  wire op_cw = acc && (req_op_i == OP_CTRL_WORD);
  wire op_rst = acc && (req_op_i == OP_RESET_SVC);

  // Status byte, bit 5 held at zero
  wire [7:0] status = {alarm_i, freq_detect_flag_i, 1'b0, overload_flag_i,
                       at_speed_flag_i, reverse_running_flag_i,
                       forward_running_flag_i, running_i};

  // Switch address, clamped to the legal range
  wire [7:0] sw_sum = {4'h0, node_sw_tens_i} * 8'h0A + {4'h0, node_sw_units_i};
  wire [5:0] sw_addr = (sw_sum > {2'h0, NODE_MAX}) ? NODE_MAX
                       : sw_sum[5:0];

  // Link state transitions
  always_comb begin
    next_state = state;
    unique case (state)
      ST_BOOT:
        if (boot_cnt >= 64'(READY_CYC - 1))
          next_state = ST_IDLE;
      ST_IDLE:
        if (acc && req_op_i == OP_CONNECT)
          next_state = ST_CONN;
      ST_CONN:
        if (expired)
          next_state = ST_LOST;
      ST_LOST:
        if (auto_back && take)
          next_state = ST_CONN;
        else if (acc && req_op_i == OP_CONNECT)
          next_state = ST_CONN;
      default: next_state = ST_BOOT;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state <= ST_BOOT;
      boot_cnt <= 64'h0;
    end else if (ce_i) begin
      state <= next_state;
      if (state == ST_BOOT)
        boot_cnt <= boot_cnt + 64'h1;
    end
  end

  assign link_ready_o = (state != ST_BOOT);

  fbd_loss_timer #(
    .MS_CYC(MS_CYC)
  ) u_loss (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .arm_i(state == ST_CONN),
    .kick_i(take),
    .epr_ms_i(epr_ms),
    .expired_o(expired)
  );

  // Link answers, one cycle after each request
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rsp_valid_o <= 1'b0;
      rsp_ok_o <= 1'b0;
      rsp_data_o <= 16'h0000;
    end else if (ce_i) begin
      rsp_valid_o <= req_valid_i;
      rsp_ok_o <= req_valid_i && ok;
      if (req_valid_i)
        rsp_data_o <= (req_op_i == OP_MONITOR) ? out_freq_i
                      : (req_op_i == OP_PARAM_RD) ? {cfg_b, cfg_a}
                      : {8'h00, status};
    end
  end

  // Run commands, setpoint and link fault
  wire fault_set = expired && !policy_ign;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      run_forward_cmd_o <= 1'b0;
      run_reverse_cmd_o <= 1'b0;
      freq_setpoint_o <= 16'h0000;
      option_link_fault_o <= 1'b0;
    end else if (ce_i) begin
      if (fault_set || op_rst || term_reset_i) begin
        run_forward_cmd_o <= 1'b0;
        run_reverse_cmd_o <= 1'b0;
      end else if (op_cw) begin
        run_forward_cmd_o <= req_data_i[CW_FWD_BIT];
        run_reverse_cmd_o <= req_data_i[CW_REV_BIT];
      end
      if (acc && req_op_i == OP_FREQ)
        freq_setpoint_o <= req_data_i;
      if (fault_set)
        option_link_fault_o <= 1'b1;
      else if (term_reset_i)
        option_link_fault_o <= 1'b0;
    end
  end

  assign coast_stop_o = option_link_fault_o;

  // Reset pulses; variant picks the clear kind
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      drive_reset_o <= 1'b0;
      param_clear_o <= 2'h0;
    end else if (ce_i) begin
      drive_reset_o <= op_rst || term_reset_i;
      param_clear_o <= op_rst ? (req_data_i[0] ? 2'h2 : 2'h1)
                       : 2'h0;
    end
  end

  // Node address, bit rate, loss policy, packet period, mode
  wire apb_wr = psel_i && penable_i && pwrite_i && ce_i;
  wire mode_ok = stopped;
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      addr_taken <= 1'b0;
      node_addr_o <= NODE_MAX;
      cfg_a <= 8'h00;
      cfg_b <= 8'h00;
      epr_ms <= EPR_DEF_MS;
      panel_unit_o <= 1'b0;
    end else if (ce_i) begin
      if (!addr_taken) begin
        addr_taken <= 1'b1;
        node_addr_o <= sw_addr;
      end else if (acc && req_op_i == OP_SET_ADDR)
        node_addr_o <= req_data_i[5:0];
      if (acc && req_op_i == OP_SET_BAUD) begin
        cfg_a[CFG_BAUD_BIT] <= req_data_i[0];
        cfg_b[CFG_BAUD_BIT] <= req_data_i[1];
      end else if (apb_wr && paddr_i == REG_CFG_A)
        cfg_a <= pwdata_i[7:0];
      else if (apb_wr && paddr_i == REG_CFG_B)
        cfg_b <= pwdata_i[7:0];
      if (acc && req_op_i == OP_SET_EPR)
        epr_ms <= req_data_i;
      else if (apb_wr && paddr_i == REG_EPR)
        epr_ms <= pwdata_i[15:0];
      if (apb_wr && paddr_i == REG_CTRL && mode_ok)
        panel_unit_o <= pwdata_i[CTRL_PANEL_BIT];
    end
  end

  assign baud_sel_o = {cfg_b[CFG_BAUD_BIT], cfg_a[CFG_BAUD_BIT]};
  assign asm_out_inst_o = ASM_OUT_DEF;
  assign asm_in_inst_o = ASM_IN_DEF;

  // Read mux, captured during the setup cycle
  wire mapped = (paddr_i[1:0] == 2'h0) && (paddr_i <= REG_EPR);
  wire [31:0] stat_word = {12'h000, baud_sel_o, node_addr_o,
                           (state == ST_CONN), link_ready_o,
                           option_link_fault_o, !panel_unit_o, status};
  logic [31:0] rd_mux;
  always_comb begin
    unique case (paddr_i)
      REG_CTRL: rd_mux = {31'h0, panel_unit_o};
      REG_CFG_A: rd_mux = {24'h0, cfg_a};
      REG_CFG_B: rd_mux = {24'h0, cfg_b};
      REG_STATUS: rd_mux = stat_word;
      REG_FREQ: rd_mux = {16'h0, freq_setpoint_o};
      REG_CMDWORD: rd_mux = {29'h0, run_reverse_cmd_o,
                             run_forward_cmd_o, 1'b0};
      REG_EPR: rd_mux = {16'h0, epr_ms};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i)
      prdata_o <= 32'h00000000;
    else if (ce_i && psel_i && !penable_i)
      prdata_o <= rd_mux;
  end

  assign pready_o = ce_i;
  assign pslverr_o = psel_i && penable_i && !mapped;

  // Terminal run input is deliberately unused
  wire unused_term = term_run_i;

  // Checks
  a_answer_only: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && rsp_valid_o |-> $past(req_valid_i))
    else $error("answer without request");
  a_no_cmd_unconn: assert property (@(posedge clk_i) disable iff (!resetn_i)
    take && state == ST_IDLE && req_op_i == OP_CTRL_WORD
    |=> rsp_valid_o && !rsp_ok_o)
    else $error("command taken before connection");
  a_reader_no_ctl: assert property (@(posedge clk_i) disable iff (!resetn_i)
    take && req_master_i && req_op_i == OP_CTRL_WORD
    |=> !rsp_ok_o)
    else $error("second master took control");
  a_fault_coasts: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && expired && !policy_ign
    |=> option_link_fault_o && coast_stop_o
        && !run_forward_cmd_o && !run_reverse_cmd_o)
    else $error("timeout did not fault and stop");
  a_ignore_keeps: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && expired && policy_ign && !option_link_fault_o
    |=> !option_link_fault_o)
    else $error("ignored loss raised fault");
  a_mode_locked: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && (running_i || run_forward_cmd_o || run_reverse_cmd_o)
    |=> $stable(panel_unit_o))
    else $error("mode changed while running");
  a_panel_reject: assert property (@(posedge clk_i) disable iff (!resetn_i)
    take && panel_unit_o && req_op_i == OP_FREQ
    |=> !rsp_ok_o ##0 $stable(freq_setpoint_o))
    else $error("panel mode took setpoint");
  a_reset_refused: assert property (@(posedge clk_i) disable iff (!resetn_i)
    take && option_link_fault_o && req_op_i == OP_RESET_SVC && !term_reset_i
    |=> !drive_reset_o && param_clear_o == 2'h0)
    else $error("reset taken during link fault");
  a_freq_range: assert property (@(posedge clk_i) disable iff (!resetn_i)
    freq_setpoint_o <= FREQ_MAX)
    else $error("setpoint above limit");
  a_addr_range: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ce_i && !addr_taken && ({node_sw_tens_i, node_sw_units_i} > 8'h63)
    |=> node_addr_o == NODE_MAX)
    else $error("node address out of range");
  a_status_bit5: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rsp_valid_o && $past(req_op_i) == OP_CTRL_WORD
    |-> rsp_data_o[5] == 1'b0)
    else $error("status bit 5 not zero");
endmodule : fbd_cmd_port

// ---- core/README_unused.sv ----
`timescale 1ns/1ps

// ---- test/fbd_master_model.sv ----
`timescale 1ns/1ps
module fbd_master_model (
  input wire logic clk_i,
  output logic req_valid_o,
  output fbd_pkg::fbd_op_t req_op_o,
  output logic req_master_o,
  output logic [15:0] req_data_o,
  input wire logic rsp_valid_i,
  input wire logic rsp_ok_i,
  input wire logic [15:0] rsp_data_i
);
  import fbd_pkg::*;

  // Idle bus at time zero
  initial begin
    req_valid_o = 1'b0;
    req_op_o = OP_MONITOR;
    req_master_o = 1'b0;
    req_data_o = 16'h0000;
  end

  // One polled request, held until its take edge, then the answer
  task automatic send(input fbd_op_t op, input logic m,
                      input logic [15:0] d, output logic ok,
                      output logic [15:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    req_valid_o <= 1'b1;
    req_op_o <= op;
    req_master_o <= m;
    req_data_o <= d;
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    req_master_o <= ~m; // Released lines stop showing old values
    req_data_o <= ~d;
    @(posedge clk_i);
    while (rsp_valid_i !== 1'b1 && n < 8) begin
      @(posedge clk_i);
      n++;
    end
    ok = (n < 8) ? rsp_ok_i : 1'bx;
    rd = rsp_data_i;
  endtask : send
endmodule : fbd_master_model

// ---- test/test_fieldbus_slave_drive_command_port.sv ----
`timescale 1ns/1ps
module test_fieldbus_slave_drive_command_port;
  import fbd_pkg::*;
  logic clk_i, resetn_i, ce_i, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, asm_out, asm_in;
  logic [31:0] pwdata, prdata, rd;
  logic req_valid, req_master, rsp_valid, rsp_ok, term_reset, term_run;
  fbd_op_t req_op;
  logic [15:0] req_data, rsp_data, out_freq, freq_sp, ld;
  logic [3:0] sw_tens, sw_units;
  logic [6:0] flags;
  logic run_fwd, run_rev, fault, coast, drv_rst, panel, ready;
  logic [1:0] pclr, baud;
  logic [1:0] clr_seen = 2'h0;
  logic [5:0] node;
  logic ok, err;
  logic prev_req = 1'b0;
  int rst_count = 0;
  int num_errors = 0;
  int comparisons = 0;

  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  fbd_cmd_port #(.READY_CYC(10), .MS_CYC(4)) fbd_cmd_port_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .req_valid_i(req_valid), .req_op_i(req_op),
    .req_master_i(req_master), .req_data_i(req_data),
    .rsp_valid_o(rsp_valid), .rsp_ok_o(rsp_ok), .rsp_data_o(rsp_data),
    .node_sw_tens_i(sw_tens), .node_sw_units_i(sw_units),
    .running_i(flags[0]), .forward_running_flag_i(flags[1]),
    .reverse_running_flag_i(flags[2]), .at_speed_flag_i(flags[3]),
    .overload_flag_i(flags[4]), .freq_detect_flag_i(flags[5]),
    .alarm_i(flags[6]), .out_freq_i(out_freq), .term_reset_i(term_reset),
    .term_run_i(term_run), .run_forward_cmd_o(run_fwd),
    .run_reverse_cmd_o(run_rev), .freq_setpoint_o(freq_sp),
    .option_link_fault_o(fault), .coast_stop_o(coast),
    .drive_reset_o(drv_rst), .param_clear_o(pclr), .panel_unit_o(panel),
    .link_ready_o(ready), .node_addr_o(node), .baud_sel_o(baud),
    .asm_out_inst_o(asm_out), .asm_in_inst_o(asm_in));

  fbd_master_model fbd_master_model_i (
    .clk_i(clk_i), .req_valid_o(req_valid), .req_op_o(req_op),
    .req_master_o(req_master), .req_data_o(req_data),
    .rsp_valid_i(rsp_valid), .rsp_ok_i(rsp_ok), .rsp_data_i(rsp_data));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : complete_run

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // Answers only follow a taken request; reset pulses are latched
  always @(posedge clk_i) begin
    prev_req <= req_valid & ce_i;
    if (resetn_i === 1'b1 && rsp_valid === 1'b1) begin
      chk(32'(prev_req), 32'h1);
    end
    if (drv_rst === 1'b1) begin
      rst_count <= rst_count + 1;
      clr_seen <= pclr;
    end
  end

  // APB read or write, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    // Only the watchdog ends a wait for pready
    while (pready !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb

  task automatic lreq(input fbd_op_t op, input logic m,
                      input logic [15:0] d, input logic exp_ok);
    fbd_master_model_i.send(op, m, d, ok, ld);
    #1;
    chk(32'(ok), 32'(exp_ok));
  endtask : lreq

  task automatic t_boot;
    int n;
    n = 0;
    tick(2);
    #1;
    chk(32'(node), 32'h2A);
    @(posedge clk_i);
    sw_tens <= 4'h7;
    sw_units <= 4'h0;
    tick(2);
    #1;
    chk(32'(node), 32'h2A);
    @(posedge clk_i);
    resetn_i <= 1'b0;
    tick(2);
    resetn_i <= 1'b1;
    tick(1);
    #1;
    chk(32'(node), 32'h3F);
    chk(32'(ready), 32'h0);
    lreq(OP_CONNECT, 1'b0, 16'h0000, 1'b0);
    while (ready !== 1'b1 && n < 40) begin
      tick(1);
      #1;
      n++;
    end
    chk(32'(ready), 32'h1);
    chk(32'(baud), 32'(BAUD_125K));
    chk({24'h0, asm_out}, 32'h15);
    chk({24'h0, asm_in}, 32'h47);
    apb(1'b0, REG_CFG_B, 32'h0);
    chk(32'(rd[CFG_POLICY_BIT]), 32'h0);
    $display("Test boot done");
  endtask : t_boot

  task automatic t_cmds;
    lreq(OP_CTRL_WORD, 1'b0, 16'h0002, 1'b0);
    lreq(OP_CONNECT, 1'b0, 16'h0000, 1'b1);
    lreq(OP_CTRL_WORD, 1'b0, 16'h0002, 1'b1);
    chk({run_rev, run_fwd}, 32'h1);
    lreq(OP_CTRL_WORD, 1'b1, 16'h0004, 1'b0);
    lreq(OP_MONITOR, 1'b1, 16'h0000, 1'b1);
    chk({16'h0, ld}, 32'h1234);
    lreq(OP_CTRL_WORD, 1'b0, 16'h0004, 1'b1);
    chk({run_rev, run_fwd}, 32'h2);
    lreq(OP_FREQ, 1'b0, FREQ_MAX, 1'b1);
    lreq(OP_FREQ, 1'b0, 16'h9C41, 1'b0);
    chk({16'h0, freq_sp}, 32'(FREQ_MAX));
    lreq(OP_FREQ, 1'b0, 16'h0001, 1'b1);
    chk({16'h0, freq_sp}, 32'h1);
    lreq(OP_CTRL_WORD, 1'b0, 16'h0000, 1'b1);
    chk({run_rev, run_fwd}, 32'h0);
    $display("Test commands done");
  endtask : t_cmds

  task automatic t_status;
    logic [6:0] f;
    for (int i = 0; i < 8; i++) begin
      f = (i == 7) ? 7'h7F : 7'(1 << i);
      @(posedge clk_i);
      flags <= f;
      apb(1'b0, REG_STATUS, 32'h0);
      chk({24'h0, rd[7:0]}, {24'h0, f[6:5], 1'b0, f[4:0]});
    end
    @(posedge clk_i);
    flags <= 7'h00;
    $display("Test status done");
  endtask : t_status

  task automatic t_mode;
    lreq(OP_CTRL_WORD, 1'b0, 16'h0002, 1'b1);
    apb(1'b1, REG_CTRL, 32'h1);
    chk(32'(panel), 32'h0);
    lreq(OP_CTRL_WORD, 1'b0, 16'h0000, 1'b1);
    @(posedge clk_i);
    flags <= 7'h01;
    apb(1'b1, REG_CTRL, 32'h1);
    chk(32'(panel), 32'h0);
    @(posedge clk_i);
    flags <= 7'h00;
    apb(1'b1, REG_CTRL, 32'h1);
    chk(32'(panel), 32'h1);
    lreq(OP_CTRL_WORD, 1'b0, 16'h0002, 1'b0);
    lreq(OP_FREQ, 1'b0, 16'h0005, 1'b0);
    lreq(OP_RESET_SVC, 1'b0, 16'h0000, 1'b0);
    lreq(OP_MONITOR, 1'b0, 16'h0000, 1'b1);
    lreq(OP_PARAM_RD, 1'b0, 16'h0000, 1'b1);
    apb(1'b1, REG_CTRL, 32'h0);
    chk(32'(panel), 32'h0);
    $display("Test modes done");
  endtask : t_mode

  task automatic t_setup;
    int n0;
    n0 = rst_count;
    lreq(OP_RESET_SVC, 1'b0, 16'h0000, 1'b1);
    tick(1);
    #1;
    chk(32'(rst_count - n0), 32'h1);
    chk(32'(clr_seen), 32'h1);
    lreq(OP_RESET_SVC, 1'b0, 16'h0001, 1'b1);
    tick(1);
    #1;
    chk(32'(clr_seen), 32'h2);
    lreq(OP_CONNECT, 1'b0, 16'h0000, 1'b1);
    apb(1'b1, REG_CFG_A, 32'h2);
    chk(32'(baud), 32'h1);
    apb(1'b1, REG_CFG_A, 32'h0);
    lreq(OP_SET_BAUD, 1'b0, 16'h0002, 1'b1);
    chk(32'(baud), 32'h2);
    lreq(OP_SET_BAUD, 1'b0, 16'h0000, 1'b1);
    lreq(OP_SET_ADDR, 1'b0, 16'h0005, 1'b1);
    lreq(OP_SET_ADDR, 1'b0, 16'h0040, 1'b0);
    chk(32'(node), 32'h5);
    apb(1'b0, 8'h1C, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("Test setup done");
  endtask : t_setup

  task automatic t_loss;
    int n;
    n = 0;
    lreq(OP_SET_EPR, 1'b0, 16'h0001, 1'b1);
    lreq(OP_CTRL_WORD, 1'b0, 16'h0002, 1'b1);
    tick(12);
    #1;
    chk({fault, run_fwd}, 32'h1);
    while (fault !== 1'b1 && n < 12) begin
      tick(1);
      #1;
      n++;
    end
    chk({coast, fault, run_fwd}, 32'h6);
    // Fault lands 16 edges after the take: four periods of four cycles
    chk(32'(n), 32'h3);
    lreq(OP_CONNECT, 1'b0, 16'h0000, 1'b1);
    lreq(OP_RESET_SVC, 1'b0, 16'h0000, 1'b0);
    @(posedge clk_i);
    term_reset <= 1'b1;
    @(posedge clk_i);
    term_reset <= 1'b0;
    #1;
    chk(32'(fault), 32'h0);
    apb(1'b1, REG_CFG_B, 32'h1);
    lreq(OP_CTRL_WORD, 1'b0, 16'h0002, 1'b1);
    tick(40);
    #1;
    chk({fault, run_fwd}, 32'h1);
    lreq(OP_MONITOR, 1'b0, 16'h0000, 1'b1);
    lreq(OP_CTRL_WORD, 1'b0, 16'h0000, 1'b1);
    lreq(OP_SET_EPR, 1'b0, 16'h0000, 1'b1);
    $display("Test link loss done");
  endtask : t_loss

  // Watchdog
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    complete_run();
  end

  initial begin
    {resetn_i, psel, penable, pwrite, term_reset, flags} = '0;
    {ce_i, term_run} = 2'h3;
    {paddr, pwdata, out_freq} = {8'h00, 32'h0, 16'h1234};
    {sw_tens, sw_units} = 8'h42;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_boot();
    t_cmds();
    t_status();
    t_mode();
    t_setup();
    t_loss();
    complete_run();
  end
endmodule : test_fieldbus_slave_drive_command_port
